// >>> hw/cpu_emu_pkg.sv
// Shared constants for the CPU-emulation command interpreter
package cpu_emu_pkg;
  // Bus cycle timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int STROBE_NS = 60;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Command word field positions
  localparam int ADDR_LSB = 0;
  localparam int ADDR_FIELD_W = 6;
  localparam int MOD_LSB = 6;
  localparam int PROC_LSB = 8;
  localparam int REP_LSB = 12;

  // Field encodings
  localparam logic [2:0] PROC_WRITE = 3'h1;
  localparam logic [2:0] PROC_READ = 3'h2;
  localparam logic [1:0] MOD_INC = 2'h2;
  localparam logic [1:0] MOD_DEC = 2'h3;

  // APB register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_STAT = 8'h08;
  localparam logic [7:0] OFS_INT_EN = 8'h0C;
  localparam logic [7:0] OFS_INT_CLR = 8'h10;
  localparam logic [7:0] OFS_RDATA = 8'h14;

  // Control bits and reset value
  localparam int CTRL_WIDE_BIT = 0;
  localparam int CTRL_EN_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h2;

  // Status bits
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_DONE_BIT = 1;
  localparam int STS_CNT_LSB = 8;

  // Interrupt event bits
  localparam int EV_DONE_BIT = 0;
  localparam int EV_UNSUP_BIT = 1;
endpackage : cpu_emu_pkg

// >>> hw/cpu_bus_cycle.sv
// One read or write cycle on the emulated CPU bus
`timescale 1ns/10ps
module cpu_bus_cycle import cpu_emu_pkg::*; #(
  parameter int ADDR_W = 6
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request from the interpreter
  input wire logic start,
  input wire logic we,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  output logic done,
  output logic [15:0] rdata,
  // Emulated CPU bus pins
  output logic [ADDR_W-1:0] cpu_addr,
  output logic cpu_cs_n,
  output logic cpu_rd_n,
  output logic cpu_wr_n,
  output logic [15:0] cpu_data_o,
  output logic cpu_data_oe,
  input wire logic [15:0] cpu_data_i
);
  typedef enum logic [2:0] {
    PH_IDLE = 3'h1,
    PH_STROBE = 3'h2,
    PH_HOLD = 3'h4
  } phase_t;

  typedef struct packed {
    phase_t ph;
    logic [7:0] cnt;
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic we;
    logic done;
    logic [15:0] rdata;
    logic [ADDR_W-1:0] addr;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [15:0] dout;
    logic oe;
  } st_t;

  st_t r, n;

  always_comb begin
    n = r;
    n.sync1 = cpu_data_i;
    n.sync2 = r.sync1;
    n.done = 1'b0;
    unique case (r.ph)
      PH_IDLE: begin
        if (start) begin
          n.ph = PH_STROBE;
          n.cnt = 8'(STROBE_CYC);
          n.we = we;
          n.addr = addr;
          n.dout = wdata;
          n.oe = we;
          n.cs_n = 1'b0;
          n.rd_n = we;
          n.wr_n = ~we;
        end
      end
      PH_STROBE: begin
        n.cnt = r.cnt - 8'h01;
        if (r.cnt == 8'h01) begin
          // Data pins pass two flops, so sample as the strobe ends
          n.rdata = r.sync2;
          n.rd_n = 1'b1;
          n.wr_n = 1'b1;
          n.ph = PH_HOLD;
        end
      end
      PH_HOLD: begin
        // One idle cycle keeps address and data stable past the strobe
        n.cs_n = 1'b1;
        n.oe = 1'b0;
        n.done = 1'b1;
        n.ph = PH_IDLE;
      end
      default: n.ph = PH_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{ph: PH_IDLE, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
    end else begin
      r <= n;
    end
  end

  assign done = r.done;
  assign rdata = r.rdata;
  assign cpu_addr = r.addr;
  assign cpu_cs_n = r.cs_n;
  assign cpu_rd_n = r.rd_n;
  assign cpu_wr_n = r.wr_n;
  assign cpu_data_o = r.dout;
  assign cpu_data_oe = r.oe;
endmodule : cpu_bus_cycle

// >>> hw/cpu_emu_interp.sv
// Command interpreter driving emulated 8/16-bit CPU bus cycles
//
// Notes on behaviour
// R1 - Start address driven; 16-bit mode clears bit0
// R2 - Modification 0X keeps the same address
// R3 - Modification 10 increments by one or two
// R4 - Modification 11 decrements by one or two
// R5 - Code 001 writes, code 010 reads
// R6 - Repetition zero runs the operation once
// R7 - Repetition N runs the operation N+1 times
// R8 - Write data words follow command, one per cycle
// R9 - Each group starts with its command word
// R10 - Stacked groups executed one after another
// R11 - Reception-complete bit set after all commands
// R12 - Host keeps batches within 256 bytes
// R13 - Host should split long batches into smaller ones
// R14 - Unknown codes consume command, no bus cycle
`timescale 1ns/10ps
module cpu_emu_interp import cpu_emu_pkg::*; #(
  parameter int ADDR_W = ADDR_FIELD_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Received word stream from the link
  input wire logic word_valid,
  input wire logic [15:0] word_data,
  output logic word_ready,
  input wire logic batch_end,
  // Read results and cyclic status
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic recv_done,
  output logic irq,
  // Emulated CPU bus
  output logic [ADDR_W-1:0] cpu_addr,
  output logic cpu_cs_n,
  output logic cpu_rd_n,
  output logic cpu_wr_n,
  output logic [15:0] cpu_data_o,
  output logic cpu_data_oe,
  input wire logic [15:0] cpu_data_i
);
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_WDATA = 4'h2,
    S_GO = 4'h4,
    S_BUSY = 4'h8
  } state_t;

  typedef struct packed {
    state_t state;
    logic [ADDR_W-1:0] addr;
    logic [1:0] amod;
    logic we;
    logic [3:0] remain;
    logic [15:0] wdata;
    logic go;
    logic word_ready;
    logic rd_valid;
    logic [15:0] rd_data;
    logic pend;
    logic done;
    logic [1:0] ctrl;
    logic [1:0] int_stat;
    logic [1:0] int_en;
    logic [7:0] unsup_cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } st_t;

  st_t r, n;
  logic cyc_done;
  logic [15:0] cyc_rdata;

  // Forces bit0 low when the emulated CPU is 16 bits wide
  function automatic logic [ADDR_W-1:0] align(input logic [ADDR_W-1:0] a,
                                               input logic wide);
    align = wide ? {a[ADDR_W-1:1], 1'b0} : a;
  endfunction : align

  function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a,
                                              input logic [1:0] m,
                                              input logic wide);
    logic [ADDR_W-1:0] s;
    s = wide ? ADDR_W'(2) : ADDR_W'(1);
    unique case (m)
      MOD_INC: begin
        // R3 increment step
        step = a + s;
      end
      MOD_DEC: begin
        // R4 decrement step
        step = a - s;
      end
      default: begin
        // R2 fixed address
        step = a;
      end
    endcase
  endfunction : step

  // One-hot register selects, shared by the read and the write path
  typedef struct packed {
    logic ctrl;
    logic status;
    logic int_stat;
    logic int_en;
    logic int_clr;
    logic rdata;
  } reg_sel_t;

  function automatic reg_sel_t decode_reg(input logic [7:0] a);
    // Any other offset leaves every select low
    decode_reg = '0;
    unique case (a)
      OFS_CTRL: decode_reg.ctrl = 1'b1;
      OFS_STATUS: decode_reg.status = 1'b1;
      OFS_INT_STAT: decode_reg.int_stat = 1'b1;
      OFS_INT_EN: decode_reg.int_en = 1'b1;
      OFS_INT_CLR: decode_reg.int_clr = 1'b1;
      OFS_RDATA: decode_reg.rdata = 1'b1;
      default: ;
    endcase
  endfunction : decode_reg

  // Fields of a command word
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [1:0] amod;
    logic [2:0] proc;
    logic [3:0] rep;
  } cmd_t;

  function automatic cmd_t decode_cmd(input logic [15:0] w);
    // Bit 11 is not decoded
    decode_cmd.addr = w[ADDR_LSB +: ADDR_W];
    decode_cmd.amod = w[MOD_LSB +: 2];
    decode_cmd.proc = w[PROC_LSB +: 3];
    decode_cmd.rep = w[REP_LSB +: 4];
  endfunction : decode_cmd

  // Clear register has no read term here, so it reads as zero
  function automatic logic [31:0] read_word(input reg_sel_t s,
                                            input st_t q);
    read_word = 32'h0000_0000;
    if (s.ctrl) begin
      read_word[1:0] = q.ctrl;
    end
    if (s.status) begin
      // Busy also covers the gap between a command and its bus cycle
      read_word[STS_BUSY_BIT] = (q.state != S_IDLE);
      read_word[STS_DONE_BIT] = q.done;
      read_word[STS_CNT_LSB +: 8] = q.unsup_cnt;
    end
    if (s.int_stat) begin
      read_word[1:0] = q.int_stat;
    end
    if (s.int_en) begin
      read_word[1:0] = q.int_en;
    end
    if (s.rdata) begin
      read_word[15:0] = q.rd_data;
    end
  endfunction : read_word

  // Words are accepted only where they are used at once, so no buffer
  function automatic logic can_take(input state_t s, input logic en);
    can_take = en && (s == S_IDLE || s == S_WDATA);
  endfunction : can_take

  cpu_bus_cycle #(
    .ADDR_W(ADDR_W)
  ) u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .start(r.go),
    .we(r.we),
    .addr(r.addr),
    .wdata(r.wdata),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .cpu_addr(cpu_addr),
    .cpu_cs_n(cpu_cs_n),
    .cpu_rd_n(cpu_rd_n),
    .cpu_wr_n(cpu_wr_n),
    .cpu_data_o(cpu_data_o),
    .cpu_data_oe(cpu_data_oe),
    .cpu_data_i(cpu_data_i)
  );

  always_comb begin
    logic wide;
    logic take;
    logic [2:0] proc;
    logic [1:0] ev;
    logic setup;
    logic wr;
    reg_sel_t sel;
    cmd_t cmd;
    wide = 1'b0;
    take = 1'b0;
    proc = 3'h0;
    ev = 2'h0;
    setup = 1'b0;
    wr = 1'b0;
    sel = '0;
    cmd = '0;
    n = r;
    wide = r.ctrl[CTRL_WIDE_BIT];
    take = word_valid && r.word_ready;
    // Decoded every cycle; only used when a command word is taken
    cmd = decode_cmd(word_data);
    proc = cmd.proc;
    n.go = 1'b0;
    n.rd_valid = 1'b0;

    // Batch end may arrive while words are still pending
    if (batch_end) begin
      n.pend = 1'b1;
    end

    unique case (r.state)
      S_IDLE: begin
        // R9 first word of a group is a command
        if (take) begin
          n.done = 1'b0;
          // R1 start address
          n.addr = align(cmd.addr, wide);
          n.amod = cmd.amod;
          // R6 zero repeats once
          // R7 count plus one
          n.remain = cmd.rep;
          // R5 write or read
          if (proc == PROC_WRITE) begin
            n.we = 1'b1;
            n.state = S_WDATA;
          end else if (proc == PROC_READ) begin
            n.we = 1'b0;
            n.state = S_GO;
          end else begin
            // R14 drop unknown command
            ev[EV_UNSUP_BIT] = 1'b1;
            n.unsup_cnt = r.unsup_cnt + 8'h01;
          end
        end else if (r.pend && !word_valid && !batch_end) begin
          // R11 all received commands handled
          n.pend = 1'b0;
          n.done = 1'b1;
          ev[EV_DONE_BIT] = 1'b1;
        end
      end
      S_WDATA: begin
        // R8 one data word per write
        if (take) begin
          n.wdata = word_data;
          n.state = S_GO;
        end
      end
      S_GO: begin
        n.go = 1'b1;
        n.state = S_BUSY;
      end
      S_BUSY: begin
        if (cyc_done) begin
          if (!r.we) begin
            n.rd_valid = 1'b1;
            n.rd_data = cyc_rdata;
          end
          // R10 next group follows
          if (r.remain == 4'h0) begin
            n.state = S_IDLE;
          end else begin
            // R7 modify between operations
            n.remain = r.remain - 4'h1;
            n.addr = align(step(r.addr, r.amod, wide), wide);
            n.state = r.we ? S_WDATA : S_GO;
          end
        end
      end
      default: n.state = S_IDLE;
    endcase

    // Stream is stalled while a cycle runs or the block is disabled
    n.word_ready = can_take(n.state, r.ctrl[CTRL_EN_BIT]);

    // APB: decode and read data are prepared in the setup cycle
    sel = decode_reg(paddr);
    setup = psel && !penable;
    wr = psel && penable && pwrite;
    // Zero wait states: every access completes in its first access cycle
    n.pready = 1'b1;
    if (setup) begin
      n.prdata = read_word(sel, r);
      // Unmapped offsets answer with an error and read as zero
      n.pslverr = (sel == '0);
    end

    n.int_stat = r.int_stat;
    // Writes to read-only offsets are dropped quietly
    if (wr && !r.pslverr) begin
      if (sel.ctrl) begin
        n.ctrl = pwdata[1:0];
      end
      if (sel.int_en) begin
        n.int_en = pwdata[1:0];
      end
      if (sel.int_clr) begin
        n.int_stat = r.int_stat & ~pwdata[1:0];
      end
    end
    // A new event wins over a clear in the same cycle
    n.int_stat = n.int_stat | ev;
    n.irq = |(n.int_stat & n.int_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{state: S_IDLE, ctrl: CTRL_RST, default: '0};
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign word_ready = r.word_ready;
  assign rd_valid = r.rd_valid;
  assign rd_data = r.rd_data;
  assign recv_done = r.done;
  assign irq = r.irq;
endmodule : cpu_emu_interp

// >>> testbench/cpu_emu_interp_assertions.sv
// Port-level checks for the command interpreter
`timescale 1ns/10ps
module cpu_emu_interp_assertions #(
  parameter int ADDR_W = 6
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Watched outputs
  input wire logic word_ready,
  input wire logic rd_valid,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic cpu_cs_n,
  input wire logic cpu_rd_n,
  input wire logic cpu_wr_n,
  input wire logic cpu_data_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_wr_strobe_len: assert property (
    $fell(cpu_wr_n) |-> !cpu_wr_n [*3] ##1 cpu_wr_n) else $error("wr len");
  a_rd_strobe_len: assert property (
    $fell(cpu_rd_n) |-> !cpu_rd_n [*3] ##1 cpu_rd_n) else $error("rd len");
  a_strobe_excl: assert property (cpu_rd_n || cpu_wr_n)
    else $error("both strobes");
  a_strobe_in_cs: assert property (!(cpu_rd_n && cpu_wr_n) |-> !cpu_cs_n)
    else $error("strobe without select");
  a_oe_write_only: assert property (cpu_data_oe |-> cpu_rd_n)
    else $error("drive during read");
  a_addr_held: assert property (
    !cpu_cs_n && $past(!cpu_cs_n) |-> $stable(cpu_addr)) else $error("addr");
  a_read_result: assert property (
    $rose(cpu_rd_n) |-> ##2 rd_valid ##1 !rd_valid) else $error("rd_valid");
  a_stall_on_bus: assert property (!cpu_cs_n |-> !word_ready)
    else $error("ready during cycle");
endmodule : cpu_emu_interp_assertions
bind cpu_emu_interp cpu_emu_interp_assertions #(.ADDR_W(ADDR_W)) i_chk (.*);

// >>> testbench/cpu_periph_model.sv
// Peripheral memory on the emulated CPU bus
`timescale 1ns/10ps
module cpu_periph_model (
  // Clock
  input wire logic pclk,
  // CPU bus from the interpreter
  input wire logic [5:0] cpu_addr,
  input wire logic cpu_cs_n,
  input wire logic cpu_rd_n,
  input wire logic cpu_wr_n,
  input wire logic [15:0] cpu_data_o,
  input wire logic cpu_data_oe,
  output logic [15:0] cpu_data_i
);
  logic [15:0] mem [64];
  logic [15:0] last = '0;
  logic wr_d = 1'b1;
  logic [31:0] wl [$];
  initial foreach (mem[i]) mem[i] = 16'hA000 + 16'(i);
  // Idle bus toggles so a stale value is never mistaken for data
  assign cpu_data_i = (!cpu_cs_n && !cpu_rd_n) ? mem[cpu_addr] : ~last;
  always @(posedge pclk) begin
    last <= cpu_data_i;
    wr_d <= cpu_wr_n;
    if (wr_d && !cpu_wr_n && !cpu_cs_n && cpu_data_oe) begin
      mem[cpu_addr] <= cpu_data_o;
      wl.push_back({10'h000, cpu_addr, cpu_data_o});
    end
  end
endmodule : cpu_periph_model

// >>> testbench/cpu_emu_interp_tb.sv
// Self-checking bench for the command interpreter
`timescale 1ns/10ps
module cpu_emu_interp_tb import cpu_emu_pkg::*; ;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rv;
  logic pready, pslverr, word_valid = 0, word_ready, batch_end = 0;
  logic [15:0] word_data = '0, rd_data, cpu_data_o, cpu_data_i;
  logic rd_valid, recv_done, irq, cpu_cs_n, cpu_rd_n, cpu_wr_n, cpu_data_oe;
  logic [5:0] cpu_addr;
  logic [15:0] rq [$];
  int err_count = 0, n_compared = 0, cyc = 0;
  always #10 pclk = ~pclk;
  cpu_emu_interp #(.ADDR_W(6)) i_dut (.*);
  cpu_periph_model i_mem (.*);
  always @(posedge pclk) begin
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d = '0);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic batch(input logic [15:0] w [$]);
    foreach (w[i]) begin
      word_valid <= 1'b1;
      word_data <= w[i];
      do @(posedge pclk); while (word_ready !== 1'b1);
    end
    word_valid <= 1'b0;
    @(posedge pclk);
    batch_end <= 1'b1;
    @(posedge pclk);
    batch_end <= 1'b0;
    repeat (300) if (recv_done !== 1'b1) @(posedge pclk);
  endtask : batch
  task automatic cmp_log(input logic [31:0] e [$]);
    chk(i_mem.wl.size(), e.size());
    foreach (e[i]) chk(i_mem.wl[i], e[i]);
    i_mem.wl.delete();
  endtask : cmp_log
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, OFS_CTRL);
    chk(rv, 32'h2);
    apb(1, OFS_INT_EN, 32'h3);
    // Command word leads each group; batch stays far below 256 bytes
    batch('{16'h1184, 16'h0100, 16'h0000, 16'h2150, 16'h0001, 16'h0002,
            16'h0003, 16'h11C8, 16'h0007, 16'h0008, 16'h0300, 16'h12A0});
    cmp_log('{32'h40100, 32'h50000, 32'h100001, 32'h100002, 32'h100003,
              32'h80007, 32'h70008});
    chk(rq.size(), 2);
    chk(rq[0], 16'hA020);
    chk(rq[1], 16'hA021);
    chk(recv_done, 1'b1);
    apb(0, OFS_STATUS);
    chk(rv[15:8], 8'h01);
    chk(rv[1:0], 2'h2);
    apb(0, OFS_INT_STAT);
    chk(rv, 32'h3);
    chk(irq, 1'b1);
    apb(1, OFS_INT_CLR, 32'h3);
    apb(0, OFS_INT_STAT);
    chk(rv, 32'h0);
    chk(irq, 1'b0);
    $display("test 1 done");
    apb(1, OFS_CTRL, 32'h3);
    batch('{16'h1185, 16'h00A1, 16'h00A2, 16'h01C9, 16'h00A3, 16'h0223});
    cmp_log('{32'h400A1, 32'h600A2, 32'h800A3});
    chk(rq[2], 16'hA022);
    apb(0, OFS_RDATA);
    chk(rv, 32'hA022);
    apb(0, 8'h40);
    chk(se, 1'b1);
    apb(1, OFS_CTRL, 32'h0);
    // Ready is registered from the control bit, one edge behind the write
    @(posedge pclk);
    chk(word_ready, 1'b0);
    $display("test 2 done");
    report_and_stop();
  end
endmodule : cpu_emu_interp_tb
